// ===== hw/universal_serial_two_wire_unit.sv
// Purpose: Serial shift unit with counter, start detector, clock hold
// Assumes: sys_clk_in 100 MHz; link_clk_in free running, own phase
// Notes:   Software drives the protocol through the control ports
`timescale 1ns/100ps
`include "usi_cfg.svh"

module universal_serial_two_wire_unit
  import usi_pkg::*;
(
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         link_clk_in,
  input  serial_ctrl_t      ctrl_in,
  input  wire logic         clock_strobe_in,
  input  wire logic         toggle_strobe_in,
  input  wire logic         timer_overflow_in,
  input  wire logic         data_write_in,
  input  shift_word_t       data_value_in,
  input  wire logic         counter_write_in,
  input  count_t            counter_value_in,
  input  wire logic         start_clear_in,
  input  wire logic         overflow_clear_in,
  input  wire logic         stop_clear_in,
  input  wire logic         start_irq_enable_in,
  input  wire logic         overflow_irq_enable_in,
  input  wire logic         data_dir_in,
  input  wire logic         clock_dir_in,
  input  wire logic         serial_clock_pin_in,
  input  wire logic         serial_data_in_pin_in,
  output logic              serial_clock_pin_out,
  output logic              serial_clock_pin_oe_out,
  output logic              serial_data_pin_out,
  output logic              serial_data_pin_oe_out,
  output logic              data_out_pin_out,
  output logic              data_out_pin_oe_out,
  output shift_word_t       shift_data_register_out,
  output serial_status_t    serial_status_register_out,
  output logic              start_irq_out,
  output logic              overflow_irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // Link domain: pin sampling and start/stop detection

  logic                          link_rst;
  logic [`USI_L_COUNT-1:0]       link_pin_raw;
  logic [`USI_L_COUNT-1:0]       link_pin_lvl;
  logic [`USI_L_COUNT-1:0]       link_pin_low;
  logic [`USI_SDA_DELAY_CYC-1:0] sda_delay_reg;
  logic                          sda_dly_prev_reg;
  logic                          scl_prev_reg;
  logic                          link_rise_tgl_reg;
  logic                          link_fall_tgl_reg;
  logic                          link_start_tgl_reg;
  logic                          link_stop_tgl_reg;
  logic                          link_rise_data_reg;
  logic                          link_scl;
  logic                          link_sda_dly;

  // Reset carried into the link domain
  bit_sync3 u_link_rst_sync
  (
    .clk_in     (link_clk_in),
    .rst_in     (`USI_LOW),
    .d_in       (rst_in),
    .level_out  (link_rst),
    .change_out ()
  );

  // Raw pins, no glitch filter on either line
  assign link_pin_raw[`USI_L_SDA] = serial_data_in_pin_in;
  assign link_pin_raw[`USI_L_SCL] = serial_clock_pin_in;

  // Pin synchronisers, inverted so reset matches the idle-high lines
  generate
    for (genvar li = 0; li < `USI_L_COUNT; li++)
    begin : g_link_pin
      bit_sync3 u_pin_sync
      (
        .clk_in     (link_clk_in),
        .rst_in     (link_rst),
        .d_in       (~link_pin_raw[li]),
        .level_out  (link_pin_low[li]),
        .change_out ()
      );
    end
  endgenerate

  assign link_pin_lvl = ~link_pin_low;
  assign link_scl     = link_pin_lvl[`USI_L_SCL];
  assign link_sda_dly = sda_delay_reg[`USI_SDA_DELAY_CYC-1];

  // Data line delay so the clock level is settled when compared
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      sda_delay_reg    <= '1;
      sda_dly_prev_reg <= `USI_HIGH;
      scl_prev_reg     <= `USI_HIGH;
    end
    else
    begin
      sda_delay_reg    <= {sda_delay_reg[`USI_SDA_DELAY_CYC-2:0],
                           link_pin_lvl[`USI_L_SDA]};
      sda_dly_prev_reg <= link_sda_dly;
      scl_prev_reg     <= link_scl;
    end
  end

  // Clock edge events, with data caught on the rising edge
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      link_rise_tgl_reg  <= `USI_LOW;
      link_fall_tgl_reg  <= `USI_LOW;
      link_rise_data_reg <= `USI_LOW;
    end
    else
    begin
      if (link_scl && !scl_prev_reg)
      begin
        link_rise_tgl_reg  <= ~link_rise_tgl_reg;
        link_rise_data_reg <= link_pin_lvl[`USI_L_SDA];
      end
      if (!link_scl && scl_prev_reg)
        link_fall_tgl_reg <= ~link_fall_tgl_reg;
    end
  end

  // Start and stop detector, independent of the system clock
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      link_start_tgl_reg <= `USI_LOW;
      link_stop_tgl_reg  <= `USI_LOW;
    end
    else
    begin
      // Data falls while clock is high
      if (link_scl && scl_prev_reg && sda_dly_prev_reg && !link_sda_dly)
        link_start_tgl_reg <= ~link_start_tgl_reg;
      // Data rises while clock is high
      if (link_scl && scl_prev_reg && !sda_dly_prev_reg && link_sda_dly)
        link_stop_tgl_reg <= ~link_stop_tgl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crossing into the system domain

  logic [`USI_X_COUNT-1:0] x_raw;
  logic [`USI_X_COUNT-1:0] x_lvl;
  logic [`USI_X_COUNT-1:0] x_chg;

  assign x_raw[`USI_X_RISE]  = link_rise_tgl_reg;
  assign x_raw[`USI_X_FALL]  = link_fall_tgl_reg;
  assign x_raw[`USI_X_START] = link_start_tgl_reg;
  assign x_raw[`USI_X_STOP]  = link_stop_tgl_reg;
  assign x_raw[`USI_X_SDA]   = serial_data_in_pin_in;
  assign x_raw[`USI_X_SCL]   = serial_clock_pin_in;

  // Toggles become pulses, pin levels become settled levels
  generate
    for (genvar xi = 0; xi < `USI_X_COUNT; xi++)
    begin : g_cross
      bit_sync3 u_x_sync
      (
        .clk_in     (sys_clk_in),
        .rst_in     (rst_in),
        .d_in       (x_raw[xi]),
        .level_out  (x_lvl[xi]),
        .change_out (x_chg[xi])
      );
    end
  endgenerate

  logic ev_rise;
  logic ev_fall;
  logic ev_start;
  logic ev_stop;
  logic sda_lvl;

  assign ev_rise  = x_chg[`USI_X_RISE];
  assign ev_fall  = x_chg[`USI_X_FALL];
  assign ev_start = x_chg[`USI_X_START];
  assign ev_stop  = x_chg[`USI_X_STOP];
  assign sda_lvl  = x_lvl[`USI_X_SDA];

  ////////////////////////////////////////////////////////////////////////
  // Clock source selection

  // True for either two-wire setting
  function automatic logic is_two_wire(input wire_mode_t wm);
    return (wm == `USI_WM_TWO) || (wm == `USI_WM_TWO_HOLD);
  endfunction

  logic   two_wire;
  logic   ext_clk;
  logic   shift_tick;
  logic   count_tick;
  logic   shift_bit;
  logic   overflow_evt;
  logic   start_set;
  count_t count_reg;
  count_t count_next;

  assign two_wire = is_two_wire(ctrl_in.wire_mode);
  assign ext_clk  = ctrl_in.external_clock_select;

  // Shift and count strobes for the selected source
  always_comb
  begin
    shift_tick = `USI_LOW;
    case ({ctrl_in.external_clock_select, ctrl_in.clock_edge_select})
      `USI_CS_STROBE:   shift_tick = clock_strobe_in;
      `USI_CS_TIMER:    shift_tick = timer_overflow_in;
      `USI_CS_EXT_RISE: shift_tick = ev_rise;
      `USI_CS_EXT_FALL: shift_tick = ev_fall;
      default:          shift_tick = `USI_LOW;
    endcase
    // External clock counts both edges, internal follows the shift
    count_tick = ext_clk ? (ev_rise | ev_fall) : shift_tick;
  end

  // Bit sampled on the rising clock edge, or the settled line
  assign shift_bit = ext_clk ? link_rise_data_reg : sda_lvl;

  // Counter wraps from maximum to zero; a write wins over a tick
  assign overflow_evt = count_tick && !counter_write_in
                        && (count_reg == `USI_CNT_MAX);
  assign count_next   = count_reg + `USI_CNT_ONE;

  // Start flag sources per wire mode
  assign start_set = two_wire ? ev_start
                   : (ext_clk && !clock_strobe_in && (ev_rise | ev_fall));

  ////////////////////////////////////////////////////////////////////////
  // Shift register and counter

  shift_word_t shift_reg;

  // Written value wins over a shift in the same cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      shift_reg <= `USI_SHIFT_RESET;
    else if (data_write_in)
      shift_reg <= data_value_in;
    else if (shift_tick)
      shift_reg <= {shift_reg[`USI_MSB_BIT-1:0], shift_bit};
  end

  // Counter advances on each serial clock
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      count_reg <= `USI_CNT_ZERO;
    else if (counter_write_in)
      count_reg <= counter_value_in;
    else if (count_tick)
      count_reg <= count_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags; a set in the clearing cycle wins

  logic start_flag_reg;
  logic overflow_flag_reg;
  logic stop_flag_reg;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      start_flag_reg <= `USI_LOW;
    else if (start_set)
      start_flag_reg <= `USI_HIGH;
    else if (start_clear_in)
      start_flag_reg <= `USI_LOW;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      overflow_flag_reg <= `USI_LOW;
    else if (overflow_evt)
      overflow_flag_reg <= `USI_HIGH;
    else if (overflow_clear_in)
      overflow_flag_reg <= `USI_LOW;
  end

  // Stop seen, two-wire only; marks end of a byte run
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      stop_flag_reg <= `USI_LOW;
    else if (two_wire && ev_stop)
      stop_flag_reg <= `USI_HIGH;
    else if (stop_clear_in)
      stop_flag_reg <= `USI_LOW;
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock hold control (two-wire modes only)

  logic start_armed_reg;
  logic start_hold_reg;
  logic overflow_hold_reg;

  // Arm on start, hold from the next falling clock until cleared
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !two_wire)
    begin
      start_armed_reg <= `USI_LOW;
      start_hold_reg  <= `USI_LOW;
    end
    else
    begin
      if (ev_start)
        start_armed_reg <= `USI_HIGH;
      else if (ev_fall || ev_stop)
        start_armed_reg <= `USI_LOW;
      if (start_armed_reg && ev_fall)
        start_hold_reg <= `USI_HIGH;
      else if (start_clear_in)
        start_hold_reg <= `USI_LOW;
    end
  end

  // Overflow forces the clock low in the holding mode
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || (ctrl_in.wire_mode != `USI_WM_TWO_HOLD))
      overflow_hold_reg <= `USI_LOW;
    else if (overflow_evt)
      overflow_hold_reg <= `USI_HIGH;
    else if (overflow_clear_in)
      overflow_hold_reg <= `USI_LOW;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers, all from flops

  logic clock_port_reg;

  // Software clock toggle, master role only
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      clock_port_reg <= `USI_HIGH;
    else if (toggle_strobe_in)
      clock_port_reg <= ~clock_port_reg;
  end

  // Clock pin: open drain in two-wire, push-pull in three-wire
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      serial_clock_pin_out    <= `USI_LOW;
      serial_clock_pin_oe_out <= `USI_LOW;
    end
    else if (two_wire)
    begin
      serial_clock_pin_out    <= `USI_LOW;
      serial_clock_pin_oe_out <= start_hold_reg || overflow_hold_reg
                                 || (clock_dir_in && !clock_port_reg);
    end
    else
    begin
      serial_clock_pin_out    <= clock_port_reg;
      serial_clock_pin_oe_out <= clock_dir_in
                                 && (ctrl_in.wire_mode == `USI_WM_THREE);
    end
  end

  // Data pins: top shift bit pulls the line low in two-wire
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      serial_data_pin_out    <= `USI_LOW;
      serial_data_pin_oe_out <= `USI_LOW;
      data_out_pin_out       <= `USI_LOW;
      data_out_pin_oe_out    <= `USI_LOW;
    end
    else
    begin
      serial_data_pin_out    <= `USI_LOW;
      serial_data_pin_oe_out <= two_wire && data_dir_in
                                && !shift_reg[`USI_MSB_BIT];
      data_out_pin_out       <= shift_reg[`USI_MSB_BIT];
      data_out_pin_oe_out    <= data_dir_in
                                && (ctrl_in.wire_mode == `USI_WM_THREE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software-visible state

  // Register image and interrupt requests
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      shift_data_register_out    <= `USI_SHIFT_RESET;
      serial_status_register_out <= '0;
      start_irq_out              <= `USI_LOW;
      overflow_irq_out           <= `USI_LOW;
    end
    else
    begin
      shift_data_register_out <= shift_reg;
      serial_status_register_out.start_detect_flag   <= start_flag_reg;
      serial_status_register_out.count_overflow_flag <= overflow_flag_reg;
      serial_status_register_out.stop_flag           <= stop_flag_reg;
      serial_status_register_out.collision <= two_wire
        && (shift_reg[`USI_MSB_BIT] != sda_lvl);
      serial_status_register_out.count <= count_reg;
      start_irq_out    <= start_flag_reg && start_irq_enable_in;
      overflow_irq_out <= overflow_flag_reg && overflow_irq_enable_in;
    end
  end

endmodule // universal_serial_two_wire_unit

// ===== hw/usi_cfg.svh
// Purpose: Named constants for the universal serial two-wire unit
// Assumes: Included by the package and by the unit's modules
// Notes:   Definitions only; named numbers live here, the type widths sit in the package
`ifndef USI_CFG_SVH
`define USI_CFG_SVH

// Shift register and counter geometry
`define USI_MSB_BIT        7
`define USI_SHIFT_RESET    8'h00
`define USI_CNT_ZERO       4'h0
`define USI_CNT_ONE        4'h1
`define USI_CNT_MAX        4'hf
`define USI_ACK_PRESET     4'he

// Wire mode encodings
`define USI_WM_OFF         2'h0
`define USI_WM_THREE       2'h1
`define USI_WM_TWO         2'h2
`define USI_WM_TWO_HOLD    2'h3

// Clock source encodings {external_clock_select, clock_edge_select}
`define USI_CS_STROBE      2'h0
`define USI_CS_TIMER       2'h1
`define USI_CS_EXT_RISE    2'h2
`define USI_CS_EXT_FALL    2'h3

// Data line delay ahead of the start comparison
`define USI_SDA_DELAY_NS     50
`define USI_SDA_DELAY_MAX_NS 300
`define USI_LINK_PERIOD_NS   32
`define USI_SDA_DELAY_CYC \
  ((`USI_SDA_DELAY_NS + `USI_LINK_PERIOD_NS - 1) / `USI_LINK_PERIOD_NS)

// Crossing lanes into the system clock domain
`define USI_X_RISE   0
`define USI_X_FALL   1
`define USI_X_START  2
`define USI_X_STOP   3
`define USI_X_SDA    4
`define USI_X_SCL    5
`define USI_X_COUNT  6

// Pin synchroniser lanes in the link domain
`define USI_L_SDA    0
`define USI_L_SCL    1
`define USI_L_COUNT  2

// Released levels
`define USI_LOW      1'b0
`define USI_HIGH     1'b1

`endif

// ===== hw/usi_pkg.sv
// Purpose: Types shared by the universal serial two-wire unit
// Assumes: Constants come from usi_cfg.svh
// Notes:   Types only
`include "usi_cfg.svh"

package usi_pkg;

  typedef logic [`USI_MSB_BIT:0] shift_word_t;
  typedef logic [3:0]            count_t;
  typedef logic [1:0]            wire_mode_t;

  // Configuration bits steering the unit
  typedef struct packed {
    wire_mode_t wire_mode;
    logic       external_clock_select;
    logic       clock_edge_select;
  } serial_ctrl_t;

  // Status as software reads it
  typedef struct packed {
    logic   start_detect_flag;
    logic   count_overflow_flag;
    logic   stop_flag;
    logic   collision;
    count_t count;
  } serial_status_t;

endpackage

// ===== hw/bit_sync3.sv
// Purpose: Three-stage synchroniser for one bit
// Assumes: d_in is asynchronous to clk_in
// Notes:   Change pulses when stage two and three differ
`timescale 1ns/100ps
`include "usi_cfg.svh"

module bit_sync3
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output logic      level_out,
  output logic      change_out
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  // Three flops; first is read only by the second
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      stage1_reg <= `USI_LOW;
      stage2_reg <= `USI_LOW;
      stage3_reg <= `USI_LOW;
    end
    else
    begin
      stage1_reg <= d_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Settled level and one-cycle change marker
  assign level_out  = stage3_reg;
  assign change_out = stage2_reg ^ stage3_reg;

endmodule // bit_sync3

// ===== testbench/universal_serial_two_wire_unit_checker.sv
// Purpose: Port assertions for the serial two-wire unit
// Assumes: Inputs stay quiet around loads and flag clears
// Notes:   Bound to the unit after the endmodule
`timescale 1ns/100ps

module usi_port_checker
  import usi_pkg::*;
(
  input  wire logic      sys_clk_in,
  input  wire logic      rst_in,
  input  serial_ctrl_t   ctrl_in,
  input  wire logic      data_write_in,
  input  shift_word_t    data_value_in,
  input  wire logic      counter_write_in,
  input  count_t         counter_value_in,
  input  wire logic      overflow_clear_in,
  input  wire logic      start_irq_enable_in,
  input  wire logic      overflow_irq_enable_in,
  input  wire logic      serial_clock_pin_out,
  input  wire logic      serial_clock_pin_oe_out,
  input  wire logic      serial_data_pin_oe_out,
  input  shift_word_t    shift_data_register_out,
  input  serial_status_t serial_status_register_out,
  input  wire logic      start_irq_out,
  input  wire logic      overflow_irq_out
);
  serial_status_t st;

  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // Short name for the status image
  assign st = serial_status_register_out;

  ////////////////////////////////////////////////////////////////////////////
  // Loads land two edges after the strobe
  a_data_load: assert property (
    data_write_in |-> ##2 shift_data_register_out == $past(data_value_in, 2))
    else $error("shift load mismatch");
  a_count_load: assert property (
    counter_write_in |-> ##2 st.count == $past(counter_value_in, 2))
    else $error("counter load mismatch");
  // Wrap from top to zero raises the overflow flag
  a_ovf_wrap: assert property (
    $past(st.count) == 4'hf && st.count == 4'h0
      && !$past(counter_write_in, 2) |-> st.count_overflow_flag)
    else $error("wrap without overflow flag");
  a_ovf_clear: assert property (
    overflow_clear_in |-> ##2 !st.count_overflow_flag)
    else $error("overflow flag not cleared");
  // Interrupt outputs follow flag and enable
  a_start_irq_on: assert property (
    (start_irq_enable_in && st.start_detect_flag) [*2] |-> start_irq_out)
    else $error("start interrupt missing");
  a_start_irq_off: assert property (
    !st.start_detect_flag |-> !start_irq_out)
    else $error("start interrupt without flag");
  a_ovf_irq_off: assert property (
    (!overflow_irq_enable_in) [*2] |-> !overflow_irq_out)
    else $error("overflow interrupt while disabled");
  // Pin drivers by wire mode
  a_sda_oe_mode: assert property (
    serial_data_pin_oe_out |->
      $past(ctrl_in.wire_mode[1]) || $past(ctrl_in.wire_mode[1], 2))
    else $error("data pin driven outside two-wire");
  a_ovf_hold: assert property (
    (ctrl_in.wire_mode == 2'h3 && st.count_overflow_flag) [*2]
      |-> serial_clock_pin_oe_out)
    else $error("clock not held after overflow");
  a_scl_low: assert property (
    $past(ctrl_in.wire_mode[1]) && $past(ctrl_in.wire_mode[1], 2)
      |-> !serial_clock_pin_out)
    else $error("clock pin level not low in two-wire");
endmodule // usi_port_checker

bind universal_serial_two_wire_unit usi_port_checker chk (.sys_clk_in,
  .rst_in, .ctrl_in, .data_write_in, .data_value_in, .counter_write_in,
  .counter_value_in, .overflow_clear_in, .start_irq_enable_in,
  .overflow_irq_enable_in, .serial_clock_pin_out, .serial_clock_pin_oe_out,
  .serial_data_pin_oe_out, .shift_data_register_out,
  .serial_status_register_out, .start_irq_out, .overflow_irq_out);

// ===== testbench/usi_bus_master.sv
// Purpose: Behavioural two-wire bus master with pulled-up lines
// Assumes: Open-drain lines; the unit only ever pulls low
// Notes:   Half period of the bus clock is HALF system cycles
`timescale 1ns/100ps

module usi_bus_master
#(
  parameter int HALF = 40
)
(
  input  wire logic clk_in,
  input  wire logic scl_oe_in,
  input  wire logic sda_oe_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic scl_rel = 1'b1;
  logic sda_rel = 1'b1;

  // Wired-and with pull-ups
  assign scl_out = scl_rel & !scl_oe_in;
  assign sda_out = sda_rel & !sda_oe_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic half();
    repeat (HALF) @(posedge clk_in);
  endtask

  // Data low with clock high, then first falling clock
  task automatic start_fall();
    sda_rel <= 1'b0;
    half();
    scl_rel <= 1'b0;
    half();
  endtask

  // One bit; waits while the clock is stretched low
  task automatic clock_bit(input logic b, output logic seen);
    sda_rel <= b;
    half();
    scl_rel <= 1'b1;
    @(posedge clk_in);
    // A stretch that never ends is caught by the bench watchdog
    while (scl_out !== 1'b1)
      @(posedge clk_in);
    half();
    seen = sda_out;
    scl_rel <= 1'b0;
    half();
  endtask

  // Single clock edge for counter use
  task automatic toggle();
    scl_rel <= !scl_rel;
    half();
  endtask
endmodule // usi_bus_master

// ===== testbench/universal_serial_two_wire_unit_bench.sv
// Purpose: Self-checking bench for the serial two-wire unit
// Assumes: 100 MHz system clock, 32 ns link clock, own phase
// Notes:   Seeded random loads plus two-wire address and ack
`timescale 1ns/100ps

module universal_serial_two_wire_unit_bench
  import usi_pkg::*;
;
  logic sys_clk_in, rst_in, link_clk_in, clock_strobe_in, toggle_strobe_in;
  logic timer_overflow_in, data_write_in, counter_write_in, start_clear_in;
  logic overflow_clear_in, stop_clear_in, start_irq_enable_in;
  logic overflow_irq_enable_in, data_dir_in, clock_dir_in;
  logic serial_clock_pin_out, serial_clock_pin_oe_out, serial_data_pin_out;
  logic serial_data_pin_oe_out, data_out_pin_out, data_out_pin_oe_out;
  logic start_irq_out, overflow_irq_out, seen;
  wire logic      serial_clock_pin_in, serial_data_in_pin_in;
  serial_ctrl_t   ctrl_in;
  shift_word_t    data_value_in, shift_data_register_out, d;
  count_t         counter_value_in;
  serial_status_t serial_status_register_out;
  int             err_total, n_checks;

  universal_serial_two_wire_unit uut (.sys_clk_in, .rst_in, .link_clk_in,
    .ctrl_in, .clock_strobe_in, .toggle_strobe_in, .timer_overflow_in,
    .data_write_in, .data_value_in, .counter_write_in, .counter_value_in,
    .start_clear_in, .overflow_clear_in, .stop_clear_in,
    .start_irq_enable_in, .overflow_irq_enable_in, .data_dir_in,
    .clock_dir_in, .serial_clock_pin_in, .serial_data_in_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe_out, .serial_data_pin_out,
    .serial_data_pin_oe_out, .data_out_pin_out, .data_out_pin_oe_out,
    .shift_data_register_out, .serial_status_register_out, .start_irq_out,
    .overflow_irq_out);

  usi_bus_master bus (.clk_in(sys_clk_in), .scl_oe_in(serial_clock_pin_oe_out),
    .sda_oe_in(serial_data_pin_oe_out), .scl_out(serial_clock_pin_in),
    .sda_out(serial_data_in_pin_in));

  ////////////////////////////////////////////////////////////////////////////
  // Clocks of unrelated phase
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = !sys_clk_in;
  end
  initial
  begin
    link_clk_in = 1'b0;
    #7;
    forever #16 link_clk_in = !link_clk_in;
  end

  // Expected shift with the idle-high data line as new bit
  function automatic shift_word_t shl(shift_word_t v);
    return {v[6:0], 1'b1};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // Load shift register and counter together
  task automatic load(input shift_word_t dv, input count_t cv);
    @(posedge sys_clk_in);
    {data_write_in, counter_write_in} <= 2'h3;
    data_value_in <= dv;
    counter_value_in <= cv;
    @(posedge sys_clk_in);
    {data_write_in, counter_write_in} <= 2'h0;
    step(4);
  endtask

  // Pulses {timer, strobe, overflow clear, start and stop clear}
  task automatic pulse(input logic [3:0] m);
    @(posedge sys_clk_in);
    {timer_overflow_in, clock_strobe_in, overflow_clear_in} <= m[3:1];
    {start_clear_in, stop_clear_in} <= {2{m[0]}};
    @(posedge sys_clk_in);
    {timer_overflow_in, clock_strobe_in, overflow_clear_in} <= 3'h0;
    {start_clear_in, stop_clear_in} <= 2'h0;
    step(6);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    step(20000);
    err_total++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    {rst_in, err_total, n_checks, ctrl_in} = {1'b1, 64'h0, 4'h0};
    {clock_strobe_in, toggle_strobe_in, timer_overflow_in} = 3'h0;
    {data_write_in, counter_write_in, start_clear_in} = 3'h0;
    {overflow_clear_in, stop_clear_in, start_irq_enable_in} = 3'h0;
    {overflow_irq_enable_in, data_dir_in, clock_dir_in} = 3'h0;
    {data_value_in, counter_value_in} = 12'h0;
    void'($urandom(32'h13c77365));
    step(12);
    rst_in <= 1'b0;
    step(2);
    check(shift_data_register_out, 8'h00);
    check(serial_status_register_out, 8'h00);
    // Random loads, each read back
    repeat (6)
    begin
      d = shift_word_t'($urandom);
      load(d, count_t'($urandom));
      check(shift_data_register_out, d);
      check(serial_status_register_out[3:0], counter_value_in);
    end
    // Software strobes: preset 14 overflows after two
    load(d, 4'he);
    pulse(4'h4);
    pulse(4'h4);
    check(shift_data_register_out, shl(shl(d)));
    check(serial_status_register_out[6:0], 7'h40);
    pulse(4'h2);
    check({7'h0, serial_status_register_out[6]}, 8'h00);
    // Timer ticks extend the timer count
    ctrl_in <= 4'h1;
    overflow_irq_enable_in <= 1'b1;
    load(d, 4'hf);
    pulse(4'h8);
    check(serial_status_register_out[6:0], 7'h40);
    check({7'h0, overflow_irq_out}, 8'h01);
    pulse(4'h3);
    overflow_irq_enable_in <= 1'b0;
    // Three-wire, external pin edges, both directions count
    ctrl_in <= 4'h6;
    load(d, 4'hf);
    bus.toggle();
    check(serial_status_register_out[6:0], 7'h40);
    check({7'h0, data_out_pin_out}, {7'h0, d[7]});
    repeat (3) bus.toggle();
    check({4'h0, serial_status_register_out.count}, 8'h03);
    // Leave the clock line high again, ready for a start
    repeat (2) bus.toggle();
    pulse(4'h3);
    // Two-wire address byte with start hold
    ctrl_in <= 4'hf;
    start_irq_enable_in <= 1'b1;
    load(8'hff, 4'h0);
    bus.start_fall();
    check({7'h0, serial_status_register_out[7]}, 8'h01);
    check({7'h0, start_irq_out}, 8'h01);
    check({7'h0, serial_clock_pin_oe_out}, 8'h01);
    pulse(4'h1);
    load(8'hff, 4'h0);
    check({7'h0, serial_clock_pin_oe_out}, 8'h00);
    d = shift_word_t'($urandom);
    for (int i = 7; i >= 0; i--)
      bus.clock_bit(d[i], seen);
    check(shift_data_register_out, d);
    // Collision bit: top shift bit against the line left at the last bit
    check(serial_status_register_out, {3'h2, d[7] ^ d[0], 4'h0});
    check({7'h0, serial_clock_pin_oe_out}, 8'h01);
    // Acknowledge bit while the master is stretched
    data_dir_in <= 1'b1;
    load(8'h00, 4'he);
    fork
      bus.clock_bit(1'b1, seen);
      pulse(4'h2);
    join
    check({7'h0, seen}, 8'h00);
    check({7'h0, serial_status_register_out[6]}, 8'h01);
    tally_and_finish();
  end
endmodule // universal_serial_two_wire_unit_bench
